// ---- pkg/hic_pkg.sv ----
// constants for the host i/o control and status block
package hic_pkg;

    // word bit 0 is the most significant bit, so word bit n sits at index 35 - n
    localparam int unsigned WORD_W = 36;
    localparam int unsigned WORD_MSB = 35;
    localparam int unsigned CNT_W = 12;
    localparam int unsigned CH_W = 3;

    // data-output word fields
    localparam int unsigned DO_IB_POS = WORD_MSB - 23;
    localparam int unsigned DO_CNT_MSB = WORD_MSB - 24;
    localparam int unsigned DO_CNT_LSB = WORD_MSB - 35;

    // condition status word fields
    localparam int unsigned ST_RM_POS = WORD_MSB - 20;
    localparam int unsigned ST_PWR_POS = WORD_MSB - 21;
    localparam int unsigned ST_FEDB_POS = WORD_MSB - 22;
    localparam int unsigned ST_MDB_POS = WORD_MSB - 26;
    localparam int unsigned ST_FEERR_POS = WORD_MSB - 27;
    localparam int unsigned ST_FEDN_POS = WORD_MSB - 29;
    localparam int unsigned ST_MDN_POS = WORD_MSB - 30;
    localparam int unsigned ST_MERR_POS = WORD_MSB - 31;
    localparam int unsigned ST_L0_POS = WORD_MSB - 32;
    localparam int unsigned ST_CH_MSB = WORD_MSB - 33;
    localparam int unsigned ST_CH_LSB = WORD_MSB - 35;
    localparam logic [35:0] ST_USED_MASK = 36'h0_0000_E37F;

    // condition write fields
    localparam int unsigned CO_FEDB_SET_POS = WORD_MSB - 22;
    localparam int unsigned CO_MDB_CLR_POS = WORD_MSB - 26;
    localparam int unsigned CO_FE_CLR_POS = WORD_MSB - 29;
    localparam int unsigned CO_MAIN_CLR_POS = WORD_MSB - 30;
    localparam int unsigned CO_LOAD_POS = WORD_MSB - 31;
    localparam int unsigned CO_L0_POS = WORD_MSB - 32;
    localparam int unsigned CO_CH_MSB = WORD_MSB - 33;
    localparam int unsigned CO_CH_LSB = WORD_MSB - 35;

    // values after reset
    localparam logic [11:0] CNT_RST = 12'h000;
    localparam logic [2:0] CH_RST = 3'h0;
    localparam logic L0_RST = 1'b0;
    localparam logic IB_RST = 1'b0;
    localparam logic [35:0] WORD_RST = 36'h0_0000_0000;

    typedef enum logic [2:0] {
        HIC_IDLE = 3'b001,
        HIC_MOVE = 3'b010,
        HIC_HOLD = 3'b100
    } hic_xfer_state_t;

endpackage

// ---- hdl/hic_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module hic_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule
`default_nettype wire

// ---- hdl/hic_count.sv ----
// negative byte counter for transfers toward the main processor
`timescale 1ns/1ps
`default_nettype none
module hic_count (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [11:0] load_value,
    input wire logic step,
    output logic [11:0] count,
    output logic at_zero
);
    logic [11:0] count_reg;

    // counts up from minus n toward zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= hic_pkg::CNT_RST;
        end else if (load) begin
            count_reg <= load_value;
        end else if (step && (count_reg != 12'h000)) begin
            count_reg <= 12'(count_reg + 12'h001);
        end
    end

    assign count = count_reg;
    assign at_zero = (count_reg == 12'h000);
endmodule
`default_nettype wire

// ---- hdl/hic_top.sv ----
// host side i/o control and status registers with the to-ten byte count
`timescale 1ns/1ps
`default_nettype none
module hic_top (
    input wire logic clk,
    input wire logic rstn,
    input wire logic host_data_write,
    input wire logic host_condition_write,
    input wire logic host_condition_read,
    input wire logic [35:0] host_wdata,
    output logic [35:0] host_rdata,
    output logic host_rdata_valid,
    input wire logic restricted_mode_pin,
    input wire logic front_end_power_low_pin,
    input wire logic fe_doorbell_request,
    input wire logic fe_doorbell_taken,
    input wire logic tofe_done_event,
    input wire logic tofe_error_event,
    input wire logic xfer_fe_parity_error,
    input wire logic xfer_fe_timeout,
    input wire logic xfer_byte_req,
    output logic xfer_byte_ack,
    output logic xfer_active,
    output logic interrupt_main,
    output logic interrupt_front_end,
    output logic front_end_doorbell_pending,
    output logic [2:0] pi_channel,
    output logic level_zero_effective
);
    logic rst_meta_reg;
    logic rst_n;
    logic restricted_mode_flag;
    logic front_end_power_fail;
    logic [1:0] pin_sync;
    hic_pkg::hic_xfer_state_t state_reg;
    hic_pkg::hic_xfer_state_t state_next;
    logic to_ten_interrupt_both_flag;
    logic main_doorbell_pending;
    logic toward_front_end_error;
    logic toward_front_end_done;
    logic toward_main_done;
    logic toward_main_error;
    logic level_zero_enable;
    logic [2:0] channel_reg;
    logic level_zero_eff_reg;
    logic [35:0] rdata_reg;
    logic rdata_valid_reg;
    logic int_main_reg;
    logic int_fe_reg;
    logic [35:0] status_word;
    logic [11:0] count;
    logic at_zero;
    logic step;
    logic err_in;
    logic err_term;
    logic done_term;
    logic clear_toward_main_flags;
    logic channel_load_strobe;

    // reset release through two flip-flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    hic_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({restricted_mode_pin, front_end_power_low_pin}),
        .sync_out(pin_sync)
    );
    assign restricted_mode_flag = pin_sync[1];
    assign front_end_power_fail = pin_sync[0];

    hic_count u_count (
        .clk(clk),
        .rst_n(rst_n),
        .load(host_data_write),
        .load_value(host_wdata[hic_pkg::DO_CNT_MSB:hic_pkg::DO_CNT_LSB]),
        .step(step),
        .count(count),
        .at_zero(at_zero)
    );

    assign err_in = xfer_fe_parity_error | xfer_fe_timeout;
    assign clear_toward_main_flags = host_condition_write
        && host_wdata[hic_pkg::CO_MAIN_CLR_POS];
    assign channel_load_strobe = host_condition_write && host_wdata[hic_pkg::CO_LOAD_POS];

    // no byte moves while the front end lacks power
    assign xfer_byte_ack = (state_reg == hic_pkg::HIC_MOVE) && !at_zero
        && !front_end_power_fail && !err_in && !host_data_write;
    assign step = xfer_byte_req && xfer_byte_ack;
    assign err_term = (state_reg != hic_pkg::HIC_IDLE) && !host_data_write && err_in;
    assign done_term = (state_reg == hic_pkg::HIC_MOVE) && !host_data_write && !err_in
        && at_zero && !front_end_power_fail;
    assign xfer_active = (state_reg != hic_pkg::HIC_IDLE);

    // transfer sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            hic_pkg::HIC_IDLE: begin
                if (host_data_write) begin
                    state_next = hic_pkg::HIC_MOVE;
                end
            end
            hic_pkg::HIC_MOVE: begin
                if (host_data_write) begin
                    state_next = hic_pkg::HIC_MOVE; // reload for scatter read
                end else if (err_in || done_term) begin
                    state_next = hic_pkg::HIC_IDLE;
                end else if (front_end_power_fail) begin
                    state_next = hic_pkg::HIC_HOLD;
                end
            end
            hic_pkg::HIC_HOLD: begin
                if (host_data_write) begin
                    state_next = hic_pkg::HIC_MOVE;
                end else if (err_in) begin
                    state_next = hic_pkg::HIC_IDLE;
                end else if (!front_end_power_fail) begin
                    state_next = hic_pkg::HIC_MOVE;
                end
            end
            default: begin
                state_next = hic_pkg::HIC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= hic_pkg::HIC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // interrupt-both choice loads with the count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            to_ten_interrupt_both_flag <= hic_pkg::IB_RST;
        end else if (host_data_write) begin
            to_ten_interrupt_both_flag <= host_wdata[hic_pkg::DO_IB_POS];
        end
    end

    // termination interrupts; errors always reach both sides
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_main_reg <= 1'b0;
            int_fe_reg <= 1'b0;
        end else begin
            int_main_reg <= done_term || err_term || fe_doorbell_request;
            int_fe_reg <= (done_term && to_ten_interrupt_both_flag) || err_term;
        end
    end

    // to-ten flags: a set in the clearing cycle wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            toward_main_done <= 1'b0;
            toward_main_error <= 1'b0;
        end else begin
            if (done_term) begin
                toward_main_done <= 1'b1;
            end else if (clear_toward_main_flags) begin
                toward_main_done <= 1'b0;
            end
            if (err_term) begin
                toward_main_error <= 1'b1;
            end else if (clear_toward_main_flags) begin
                toward_main_error <= 1'b0;
            end
        end
    end

    // toward-front-end flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            toward_front_end_done <= 1'b0;
            toward_front_end_error <= 1'b0;
        end else begin
            if (tofe_done_event && !tofe_error_event) begin
                toward_front_end_done <= 1'b1;
            end else if (host_condition_write && host_wdata[hic_pkg::CO_FE_CLR_POS]) begin
                toward_front_end_done <= 1'b0;
            end
            if (tofe_error_event) begin
                toward_front_end_error <= 1'b1;
            end else if (host_condition_write && host_wdata[hic_pkg::CO_FE_CLR_POS]) begin
                toward_front_end_error <= 1'b0;
            end
        end
    end

    // doorbells in both directions
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            front_end_doorbell_pending <= 1'b0;
            main_doorbell_pending <= 1'b0;
        end else begin
            if (host_condition_write && host_wdata[hic_pkg::CO_FEDB_SET_POS]) begin
                front_end_doorbell_pending <= 1'b1;
            end else if (fe_doorbell_taken) begin
                front_end_doorbell_pending <= 1'b0;
            end
            if (fe_doorbell_request) begin
                main_doorbell_pending <= 1'b1;
            end else if (host_condition_write && host_wdata[hic_pkg::CO_MDB_CLR_POS]) begin
                main_doorbell_pending <= 1'b0;
            end
        end
    end

    // channel and level-zero enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_reg <= hic_pkg::CH_RST;
            level_zero_enable <= hic_pkg::L0_RST;
        end else if (channel_load_strobe) begin
            channel_reg <= host_wdata[hic_pkg::CO_CH_MSB:hic_pkg::CO_CH_LSB];
            level_zero_enable <= host_wdata[hic_pkg::CO_L0_POS];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_zero_eff_reg <= 1'b0;
        end else begin
            level_zero_eff_reg <= level_zero_enable || !restricted_mode_flag;
        end
    end

    // status word; every other bit reads zero
    always_comb begin
        status_word = hic_pkg::WORD_RST;
        status_word[hic_pkg::ST_RM_POS] = restricted_mode_flag;
        status_word[hic_pkg::ST_PWR_POS] = front_end_power_fail;
        status_word[hic_pkg::ST_FEDB_POS] = front_end_doorbell_pending;
        status_word[hic_pkg::ST_MDB_POS] = main_doorbell_pending;
        status_word[hic_pkg::ST_FEERR_POS] = toward_front_end_error;
        status_word[hic_pkg::ST_FEDN_POS] = toward_front_end_done;
        status_word[hic_pkg::ST_MDN_POS] = toward_main_done;
        status_word[hic_pkg::ST_MERR_POS] = toward_main_error;
        status_word[hic_pkg::ST_L0_POS] = level_zero_enable;
        status_word[hic_pkg::ST_CH_MSB:hic_pkg::ST_CH_LSB] = channel_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= hic_pkg::WORD_RST;
            rdata_valid_reg <= 1'b0;
        end else begin
            rdata_valid_reg <= host_condition_read;
            if (host_condition_read) begin
                rdata_reg <= status_word;
            end
        end
    end

    assign host_rdata = rdata_reg;
    assign host_rdata_valid = rdata_valid_reg;
    assign interrupt_main = int_main_reg;
    assign interrupt_front_end = int_fe_reg;
    assign pi_channel = channel_reg;
    assign level_zero_effective = level_zero_eff_reg;

    chk_ib_load: assert property (
        @(posedge clk) disable iff (!rst_n)
        host_data_write |=> to_ten_interrupt_both_flag == $past(host_wdata[hic_pkg::DO_IB_POS])
    ) else $error("interrupt-both flag not taken from write");

    chk_count_load: assert property (
        @(posedge clk) disable iff (!rst_n)
        host_data_write |=> (count == $past(host_wdata[11:0])) && xfer_active
    ) else $error("byte count not loaded whole");

    chk_norm_irq: assert property (
        @(posedge clk) disable iff (!rst_n)
        done_term |=> interrupt_main && (interrupt_front_end == $past(to_ten_interrupt_both_flag))
    ) else $error("normal termination interrupt wrong");

    chk_zero_count: assert property (
        @(posedge clk) disable iff (!rst_n)
        (host_data_write && host_wdata[11:0] == 12'h000 && !front_end_power_fail
            && !host_condition_write) ##1 (!host_data_write && !err_in && !front_end_power_fail)
        |-> !xfer_byte_ack ##1 toward_main_done
    ) else $error("zero count moved a byte or did not finish");

    chk_power_block: assert property (
        @(posedge clk) disable iff (!rst_n)
        front_end_power_fail |-> !xfer_byte_ack && !done_term
    ) else $error("transfer while front end lacks power");

    chk_status_mode: assert property (
        @(posedge clk) disable iff (!rst_n)
        host_condition_read |=> host_rdata[hic_pkg::ST_RM_POS] == $past(restricted_mode_flag)
    ) else $error("restricted mode bit misreported");

    chk_error_nodone: assert property (
        @(posedge clk) disable iff (!rst_n)
        err_term |=> toward_main_error && !$rose(toward_main_done)
    ) else $error("done set on error termination");

    chk_channel_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        !channel_load_strobe |=> $stable(pi_channel) && $stable(level_zero_enable)
    ) else $error("channel changed without load strobe");

    chk_clear_main: assert property (
        @(posedge clk) disable iff (!rst_n)
        clear_toward_main_flags && !done_term && !err_term |=> !toward_main_done
            && !toward_main_error
    ) else $error("to-ten flags not cleared");

    chk_priv_enable: assert property (
        @(posedge clk) disable iff (!rst_n)
        !restricted_mode_flag |=> level_zero_effective
    ) else $error("privileged front end not level-zero enabled");

    chk_reserved_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        host_rdata_valid |-> (host_rdata & ~hic_pkg::ST_USED_MASK) == 36'h0_0000_0000
    ) else $error("unused status bit read nonzero");
endmodule
`default_nettype wire

// ---- tb/hic_host_model.sv ----
// partner model: main processor i/o instruction side issuing host strobes
`timescale 1ns/1ps
`default_nettype none
module hic_host_model (
    input wire logic clk,
    output logic host_data_write,
    output logic host_condition_write,
    output logic host_condition_read,
    output logic [35:0] host_wdata,
    input wire logic [35:0] host_rdata,
    input wire logic host_rdata_valid
);
    initial begin
        host_data_write = 1'b0;
        host_condition_write = 1'b0;
        host_condition_read = 1'b0;
        host_wdata = 36'h0_0000_0000;
    end
    // one strobe, taken at one edge; released data lines are scrambled
    task automatic strobe(input int k, input logic [35:0] w);
        @(negedge clk);
        host_wdata = w;
        case (k)
            0: host_data_write = 1'b1;
            1: host_condition_write = 1'b1;
            default: host_condition_read = 1'b1;
        endcase
        @(negedge clk);
        host_data_write = 1'b0;
        host_condition_write = 1'b0;
        host_condition_read = 1'b0;
        host_wdata = ~w;
    endtask
    // reload of the count is legal at any time, also after a main-only end
    task automatic data_write(input logic [11:0] cnt, input logic ib);
        logic [35:0] w;
        w = 36'h0_0000_0000;
        w[12] = ib;
        w[11:0] = cnt;
        strobe(0, w); // reserved bits 0-22 left zero
    endtask
    task automatic cond_write(input logic [35:0] w);
        strobe(1, w);
    endtask
    task automatic cond_read(output logic [35:0] r, output logic ok);
        ok = 1'b0;
        r = 36'h0_0000_0000;
        strobe(2, host_wdata);
        for (int i = 0; i < 4 && !ok; i++) begin
            if (host_rdata_valid === 1'b1) begin
                ok = 1'b1;
                r = host_rdata;
            end else begin
                @(negedge clk);
            end
        end
    endtask
endmodule
`default_nettype wire

// ---- tb/host_io_control_status_tb_top.sv ----
// self-checking bench for the host i/o control and status block
`timescale 1ns/1ps
`default_nettype none
module host_io_control_status_tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic rm_pin = 1'b0;
    logic pwr_pin = 1'b0;
    logic req = 1'b0;
    logic [5:0] evs = 6'h00;
    logic hdw, hcw, hcr, rvalid, ack, active, int_m, int_fe, fedb_out, l0_eff;
    logic [35:0] wdata, rdata;
    logic [2:0] ch_out;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int acks = 0;
    int n_im = 0;
    int n_ife = 0;
    bit m_rm, m_pwr, m_fedb, m_mdb, m_feerr, m_fedn, m_mdn, m_merr, m_l0;
    bit [2:0] m_ch;

    always #5 clk = ~clk;

    hic_host_model host (.clk(clk), .host_data_write(hdw), .host_condition_write(hcw),
        .host_condition_read(hcr), .host_wdata(wdata), .host_rdata(rdata),
        .host_rdata_valid(rvalid));

    hic_top dut (.clk(clk), .rstn(rstn), .host_data_write(hdw), .host_condition_write(hcw),
        .host_condition_read(hcr), .host_wdata(wdata), .host_rdata(rdata),
        .host_rdata_valid(rvalid), .restricted_mode_pin(rm_pin),
        .front_end_power_low_pin(pwr_pin), .fe_doorbell_request(evs[0]),
        .fe_doorbell_taken(evs[1]), .tofe_done_event(evs[2]), .tofe_error_event(evs[3]),
        .xfer_fe_parity_error(evs[4]), .xfer_fe_timeout(evs[5]), .xfer_byte_req(req),
        .xfer_byte_ack(ack), .xfer_active(active), .interrupt_main(int_m),
        .interrupt_front_end(int_fe), .front_end_doorbell_pending(fedb_out),
        .pi_channel(ch_out), .level_zero_effective(l0_eff));

    // byte moves and interrupt pulses seen at each edge
    always @(posedge clk) begin
        cycles++;
        if (req === 1'b1 && ack === 1'b1) acks++;
        if (int_m === 1'b1) n_im++;
        if (int_fe === 1'b1) n_ife++;
        if (cycles == 20000) begin
            err_count++;
            $display("[ERR] %0t run did not finish in time", $time);
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cmp36(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t status got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic cmp_int(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            err_count++;
            $display("[ERR] %0t count got %0d exp %0d", $time, got, exp);
        end
    endtask

    // index is 35 minus the word bit
    function automatic logic [35:0] wb(input int n);
        logic [35:0] w;
        w = 36'h0_0000_0000;
        w[35-n] = 1'b1;
        return w;
    endfunction
    function automatic logic [35:0] exp_status();
        logic [35:0] s;
        s = 36'h0_0000_0000;
        s[15] = m_rm;
        s[14] = m_pwr;
        s[13] = m_fedb;
        s[9] = m_mdb;
        s[8] = m_feerr;
        s[6] = m_fedn;
        s[5] = m_mdn;
        s[4] = m_merr;
        s[3] = m_l0;
        s[2:0] = m_ch;
        return s;
    endfunction
    task automatic check_status();
        logic [35:0] r;
        logic ok;
        host.cond_read(r, ok);
        cmp1(ok, 1'b1);
        cmp36(r, exp_status());
        cmp1(fedb_out, m_fedb);
        cmp1(ch_out[2], m_ch[2]);
        cmp1(ch_out[1:0] == m_ch[1:0], 1'b1);
    endtask
    task automatic pulse(input int k);
        @(negedge clk);
        evs[k] = 1'b1;
        @(negedge clk);
        evs = 6'h00;
    endtask

    task automatic xfer(input int n, input logic ib, input bit stall);
        host.cond_write(wb(30));
        m_mdn = 1'b0;
        if (stall) begin
            pwr_pin = 1'b1;
            m_pwr = 1'b1;
            repeat (4) @(negedge clk);
        end
        host.data_write(12'h800, ~ib); // decoy, replaced whole by the next write
        host.data_write(12'h000 - n[11:0], ib);
        acks = 0;
        n_im = 0;
        n_ife = 0;
        req = 1'b1;
        if (stall) begin
            repeat (10) @(negedge clk);
            cmp_int(acks, 0);
            cmp_int(n_im, 0);
            pwr_pin = 1'b0;
            m_pwr = 1'b0;
        end
        for (int i = 0; i < 50 && active !== 1'b0; i++) @(negedge clk);
        repeat (3) @(negedge clk);
        req = 1'b0;
        cmp_int(acks, n);
        cmp_int(n_im, 1);
        cmp_int(n_ife, int'(ib));
        m_mdn = 1'b1;
        check_status();
    endtask

    task automatic xerr(input int k);
        host.cond_write(wb(30));
        m_mdn = 1'b0;
        host.data_write(12'hFFB, 1'b0);
        acks = 0;
        n_im = 0;
        n_ife = 0;
        repeat (2) @(negedge clk);
        pulse(4 + k);
        repeat (4) @(negedge clk);
        cmp1(active, 1'b0);
        cmp_int(n_im, 1);
        cmp_int(n_ife, 1);
        m_merr = 1'b1;
        check_status();
        host.cond_write(wb(30));
        m_merr = 1'b0;
        check_status();
    endtask

    initial begin
        logic [35:0] w;
        logic [2:0] ch;
        logic l0;
        void'($urandom(32'h0cf3));
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        repeat (6) @(negedge clk);
        check_status();
        cmp1(l0_eff, 1'b1);
        for (int t = 0; t < 6; t++) begin
            ch = $urandom;
            l0 = $urandom;
            rm_pin = $urandom;
            m_rm = rm_pin;
            w = wb(31);
            w[3] = l0;
            w[2:0] = ch;
            host.cond_write(w);
            m_ch = ch;
            m_l0 = l0;
            repeat (3) @(negedge clk);
            check_status();
            cmp1(l0_eff, l0 | ~m_rm);
            w[4] = 1'b0;
            w[3:0] = ~w[3:0];
            host.cond_write(w);
            check_status();
        end
        pwr_pin = 1'b1;
        m_pwr = 1'b1;
        repeat (4) @(negedge clk);
        check_status();
        pwr_pin = 1'b0;
        m_pwr = 1'b0;
        repeat (4) @(negedge clk);
        for (int t = 0; t < 7; t++) begin
            xfer((t < 2) ? t : $urandom_range(2, 7), $urandom, t == 6);
        end
        xerr(0);
        xerr(1);
        pulse(0);
        m_mdb = 1'b1;
        check_status();
        host.cond_write(wb(26));
        m_mdb = 1'b0;
        host.cond_write(wb(22));
        m_fedb = 1'b1;
        check_status();
        pulse(1);
        m_fedb = 1'b0;
        pulse(3);
        m_feerr = 1'b1;
        check_status();
        pulse(2);
        m_fedn = 1'b1;
        check_status();
        host.cond_write(wb(29));
        m_feerr = 1'b0;
        m_fedn = 1'b0;
        check_status();
        print_verdict();
    end
endmodule
`default_nettype wire
